// file: mfc_pkg.sv
// Constants, types and code tables for the memory fault correction and logging block
package mfc_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned GRACE_US = 3500;
  localparam int unsigned HOLD_MS = 300;
  localparam int unsigned SETTLE_MS = 600;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned GRACE_CYC_DEF = GRACE_US * CLK_MHZ;
  localparam int unsigned HOLD_CYC_DEF = HOLD_MS * US_PER_MS * CLK_MHZ;
  localparam int unsigned SETTLE_CYC_DEF = SETTLE_MS * US_PER_MS * CLK_MHZ;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SYN_W = 5;
  localparam int CHK_STORED_W = 4;
  localparam int LOG_AW = 10;
  localparam int LOG_DEPTH = 1024;
  localparam int NUM_CTRL = 2;
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_W = 2;
  localparam int CSA_LO = 1;
  localparam int CSA_HI = 3;
  localparam int BUF_WORDS = 32;
  localparam int BUF_IDX_W = 5;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_SYN = 8'h10;
  localparam int BUF_SEL_BIT = 7;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_DIR_BIT = 1;
  localparam int CMD_SEL_BIT = 2;
  localparam int STAT_CPERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_GUARD_BIT = 2;
  localparam int LEN_W = 11;

  // ------------------------------------------------------------------
  // Memory operation codes and power-fail sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NOP = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2,
    OP_SET_ONES = 2'h3
  } mfc_op_t;

  typedef enum logic [3:0] {
    PF_IDLE = 4'h1,
    PF_GRACE = 4'h2,
    PF_HOLD = 4'h4,
    PF_WAIT = 4'h8
  } mfc_pf_t;

  // Syndrome of each data bit; single-bit codes belong to the check bits
  localparam logic [SYN_W-1:0] DATA_CODE [DATA_W] = '{
    5'h03, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0C, 5'h11, 5'h12,
    5'h14, 5'h18, 5'h07, 5'h0B, 5'h0D, 5'h0E, 5'h13, 5'h15
  };

  // Check bit k (A = bit 0 .. E = bit 4) covers bits whose code has bit k set
  function automatic logic [SYN_W-1:0] mfc_check(input logic [DATA_W-1:0] d);
    logic [SYN_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      c = c ^ (DATA_CODE[i] & {SYN_W{d[i]}});
    end
    return c;
  endfunction

endpackage

// file: mfc_top.sv
// Memory fault correction, error logging, log host port and power-fail sequencing
// ------------------------------------------------------------------
// Functional notes
// - Write computes five check bits from data
// - Bit A beside data; B-E in check array
// - Check array: four groups of 32K-by-4
// - Sector from address MSB and bank bit
// - Check array mirrors main array operation, address
// - Read syndrome from data, A, stored B-E
// - Zero syndrome latched, data passed unmodified
// - Nonzero syndrome inverts one identified data bit
// - Log a one on reads only
// - Log address: syndrome, address 1-3, selects
// - Host log access only in refresh slots
// - Host direct commands choose read or write
// - All log transfers pass local buffer
// - Two controllers, host selects before transfer
// - Counter matches refresh counter, copy, increment
// - Log write: buffer drives log on match
// - Sticky copy-error flag on copied one
// - Guard memory 3.5 ms after warning
// - 300 ms hold, release on warning gone
// - Protected while power low; 0.6 s settle
// - Clear log when backup rail good
// - Read-then-set-ones reads, then stores ones
// - Write stores sixteen data plus bit A
// ------------------------------------------------------------------
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module mfc_top
  import mfc_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter int unsigned GRACE_CYC = GRACE_CYC_DEF,
  parameter int unsigned HOLD_CYC = HOLD_CYC_DEF,
  parameter int unsigned SETTLE_CYC = SETTLE_CYC_DEF
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic MEM_OP_VALID,
  input wire logic [1:0] MEMORY_OP_CODE,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic BANK_SELECT_BIT,
  input wire logic ADDRESS_MSB_SELECT,
  input wire logic [DATA_W-1:0] WR_DATA,
  input wire logic [DATA_W-1:0] RD_DATA,
  input wire logic RD_CHECK_A,
  input wire logic REFRESH_SLOT,
  input wire logic DISABLE_CORRECTION_N,
  input wire logic ALT_LOG_SET,
  input wire logic [LOG_AW-1:0] ALT_LOG_ADDR,
  input wire logic POWER_LOSS_WARNING_N,
  input wire logic POWER_GOOD,
  input wire logic BACKUP_RAIL_OK,
  output logic WR_CHECK_A,
  output logic [DATA_W-1:0] OUT_DATA,
  output logic OUT_VALID,
  output logic [SYN_W-1:0] OUT_SYNDROME,
  output logic ERROR_SEEN,
  output logic MEM_GUARD_N
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam int CHK_AW = ADDR_W + GROUP_W;
  localparam int CHK_DEPTH = NUM_GROUPS << ADDR_W;

  logic [CHK_STORED_W-1:0] chk_mem [CHK_DEPTH];
  logic [CHK_AW-1:0] chk_idx;
  logic [SYN_W-1:0] gen_wr;
  logic [SYN_W-1:0] gen_rd;
  logic [SYN_W-1:0] syn_comb;
  logic [DATA_W-1:0] st_data;
  logic op_ok;
  logic op_rd;
  logic op_wr;
  logic op_ones;

  logic stg_valid_q;
  logic [SYN_W-1:0] syn_q;
  logic [DATA_W-1:0] raw_q;
  logic [LOG_AW-SYN_W-1:0] loc_q;
  logic [DATA_W-1:0] fixed;
  logic log_set;
  logic [LOG_AW-1:0] log_set_addr;

  logic [LOG_DEPTH-1:0] log_q [NUM_CTRL];
  logic [LOG_DEPTH-1:0] buf_q;
  logic [LOG_AW-1:0] rfsh_cnt_q;
  logic [LOG_AW-1:0] xfer_addr_q;
  logic [LEN_W-1:0] xfer_left_q;
  logic busy_q;
  logic dir_wr_q;
  logic sel_q;
  logic [LOG_AW-1:0] start_q;
  logic [LEN_W-1:0] len_q;
  logic cperr_q;
  logic slot_hit;
  logic rail_q;
  logic rail_rise;

  logic ack_q;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic is_buf;
  logic [BUF_IDX_W-1:0] buf_word;
  logic [31:0] rd_mux;

  mfc_pf_t pf_q;
  logic [31:0] pf_cnt_q;
  logic [31:0] settle_q;
  logic settled;
  logic release_ok;

  // ------------------------------------------------------------------
  // Check-bit generation and check array
  // ------------------------------------------------------------------
  // Guarded memory ignores operations: the array clocks are off
  assign op_ok = MEM_OP_VALID & MEM_GUARD_N;
  assign op_wr = op_ok & (MEMORY_OP_CODE == OP_WRITE);
  assign op_ones = op_ok & (MEMORY_OP_CODE == OP_SET_ONES);
  assign op_rd = op_ok & ((MEMORY_OP_CODE == OP_READ) | op_ones);
  assign chk_idx = {ADDRESS_MSB_SELECT, BANK_SELECT_BIT, MEM_ADDR};
  // Ones pattern is what the main array stores after a read-then-set
  assign st_data = op_ones ? {DATA_W{1'b1}} : WR_DATA;
  assign gen_wr = mfc_check(st_data);
  assign gen_rd = mfc_check(RD_DATA);
  assign syn_comb = gen_rd ^ {chk_mem[chk_idx], RD_CHECK_A};

  // Same address and operation as the main array; storage needs no refresh
  always_ff @(posedge CORE_CLK) begin
    if (op_wr | op_ones) begin
      chk_mem[chk_idx] <= gen_wr[SYN_W-1:1];
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WR_CHECK_A <= 1'b0;
    end else if (op_wr | op_ones) begin
      WR_CHECK_A <= gen_wr[0];
    end
  end

  // ------------------------------------------------------------------
  // Syndrome latch, correction and output
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stg_valid_q <= 1'b0;
      syn_q <= '0;
      raw_q <= '0;
      loc_q <= '0;
    end else begin
      stg_valid_q <= op_rd;
      if (op_rd) begin
        syn_q <= syn_comb;
        raw_q <= RD_DATA;
        loc_q <= {MEM_ADDR[CSA_HI:CSA_LO], ADDRESS_MSB_SELECT, BANK_SELECT_BIT};
      end
    end
  end

  always_comb begin
    fixed = raw_q;
    for (int i = 0; i < DATA_W; i++) begin
      if (DISABLE_CORRECTION_N && (syn_q == DATA_CODE[i])) begin
        fixed[i] = ~raw_q[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OUT_DATA <= '0;
      OUT_VALID <= 1'b0;
      OUT_SYNDROME <= '0;
      ERROR_SEEN <= 1'b0;
    end else begin
      OUT_VALID <= stg_valid_q;
      ERROR_SEEN <= log_set;
      if (stg_valid_q) begin
        OUT_DATA <= fixed;
        OUT_SYNDROME <= syn_q;
      end
    end
  end

  // Writes never reach this: stg_valid_q follows reads only
  assign log_set = stg_valid_q & (syn_q != '0);
  assign log_set_addr = {syn_q, loc_q};

  // ------------------------------------------------------------------
  // Error log arrays, buffer and refresh-slot transfer engine
  // ------------------------------------------------------------------
  assign rail_rise = BACKUP_RAIL_OK & ~rail_q;
  assign slot_hit = busy_q & REFRESH_SLOT & (xfer_addr_q == rfsh_cnt_q);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rail_q <= 1'b0;
      rfsh_cnt_q <= '0;
    end else begin
      rail_q <= BACKUP_RAIL_OK;
      if (REFRESH_SLOT) begin
        rfsh_cnt_q <= rfsh_cnt_q + 1'b1;
      end
    end
  end

  // Logged errors override a clearing write in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (rail_rise) begin
      for (int c = 0; c < NUM_CTRL; c++) begin
        log_q[c] <= '0;
      end
    end else begin
      if (slot_hit && dir_wr_q) begin
        log_q[sel_q][xfer_addr_q] <= buf_q[xfer_addr_q];
      end
      if (log_set) begin
        log_q[0][log_set_addr] <= 1'b1;
      end
      if (ALT_LOG_SET) begin
        log_q[1][ALT_LOG_ADDR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_q <= '0;
    end else if (slot_hit && !dir_wr_q) begin
      buf_q[xfer_addr_q] <= log_q[sel_q][xfer_addr_q];
    end else if (bus_wr && is_buf && !busy_q) begin
      for (int b = 0; b < 4; b++) begin
        if (AVS_BYTEENABLE[b]) begin
          buf_q[{buf_word, 5'(b * 8)} +: 8] <= AVS_WRITEDATA[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_q <= 1'b0;
      dir_wr_q <= 1'b0;
      sel_q <= 1'b0;
      xfer_addr_q <= '0;
      xfer_left_q <= '0;
    end else if (bus_wr && !is_buf && AVS_ADDRESS == REG_CMD && AVS_BYTEENABLE[0]
                 && AVS_WRITEDATA[CMD_START_BIT] && !busy_q && len_q != '0) begin
      busy_q <= 1'b1;
      dir_wr_q <= AVS_WRITEDATA[CMD_DIR_BIT];
      sel_q <= AVS_WRITEDATA[CMD_SEL_BIT];
      xfer_addr_q <= start_q;
      xfer_left_q <= len_q;
    end else if (slot_hit) begin
      xfer_addr_q <= xfer_addr_q + 1'b1;
      xfer_left_q <= xfer_left_q - 1'b1;
      if (xfer_left_q == LEN_W'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cperr_q <= 1'b0;
    end else if (slot_hit && !dir_wr_q && log_q[sel_q][xfer_addr_q]) begin
      cperr_q <= 1'b1;
    end else if (bus_wr && !is_buf && AVS_ADDRESS == REG_STAT && AVS_BYTEENABLE[0]
                 && AVS_WRITEDATA[STAT_CPERR_BIT]) begin
      cperr_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ------------------------------------------------------------------
  assign bus_req = (AVS_READ | AVS_WRITE) & ~ack_q;
  // Writes land only at the edge where waitrequest is seen low
  assign bus_wr = AVS_WRITE & ack_q;
  assign bus_rd = AVS_READ & ~ack_q;
  assign AVS_WAITREQUEST = bus_req;
  assign is_buf = AVS_ADDRESS[BUF_SEL_BIT];
  assign buf_word = AVS_ADDRESS[BUF_IDX_W+1:2];

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      start_q <= '0;
      len_q <= '0;
    end else if (bus_wr && !is_buf && AVS_BYTEENABLE[0] && !busy_q) begin
      if (AVS_ADDRESS == REG_START) begin
        start_q <= AVS_WRITEDATA[LOG_AW-1:0];
      end
      if (AVS_ADDRESS == REG_LEN) begin
        len_q <= AVS_WRITEDATA[LEN_W-1:0];
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    if (is_buf) begin
      rd_mux = buf_q[{buf_word, 5'h0} +: 32];
    end else begin
      case (AVS_ADDRESS)
        REG_CMD: begin
          rd_mux[CMD_DIR_BIT] = dir_wr_q;
          rd_mux[CMD_SEL_BIT] = sel_q;
        end
        REG_START: rd_mux[LOG_AW-1:0] = start_q;
        REG_LEN: rd_mux[LEN_W-1:0] = len_q;
        REG_STAT: begin
          rd_mux[STAT_CPERR_BIT] = cperr_q;
          rd_mux[STAT_BUSY_BIT] = busy_q;
          rd_mux[STAT_GUARD_BIT] = ~MEM_GUARD_N;
        end
        REG_SYN: rd_mux[SYN_W-1:0] = OUT_SYNDROME;
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q <= 1'b0;
      AVS_READDATA <= '0;
    end else begin
      ack_q <= bus_req;
      if (bus_rd) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------------
  // Power-fail sequencer
  // ------------------------------------------------------------------
  // Counters run on the core clock; no separate timer domain
  assign settled = (settle_q >= SETTLE_CYC);
  assign release_ok = POWER_LOSS_WARNING_N & POWER_GOOD & settled;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      settle_q <= '0;
    end else if (!POWER_LOSS_WARNING_N) begin
      settle_q <= '0;
    end else if (!settled) begin
      settle_q <= settle_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pf_q <= PF_IDLE;
      pf_cnt_q <= '0;
    end else begin
      case (pf_q)
        PF_IDLE: begin
          pf_cnt_q <= '0;
          if (!POWER_LOSS_WARNING_N) begin
            pf_q <= PF_GRACE;
          end
        end
        PF_GRACE: begin
          pf_cnt_q <= pf_cnt_q + 32'h0000_0001;
          if (pf_cnt_q >= GRACE_CYC - 1) begin
            pf_cnt_q <= '0;
            pf_q <= PF_HOLD;
          end
        end
        PF_HOLD: begin
          pf_cnt_q <= pf_cnt_q + 32'h0000_0001;
          if (pf_cnt_q >= HOLD_CYC - 1) begin
            pf_q <= release_ok ? PF_IDLE : PF_WAIT;
          end
        end
        PF_WAIT: begin
          pf_cnt_q <= '0;
          if (release_ok) begin
            pf_q <= PF_IDLE;
          end
        end
        default: begin
          pf_q <= PF_IDLE;
          pf_cnt_q <= '0;
        end
      endcase
    end
  end

  // Guard stays on whenever power is not good, even while idle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_GUARD_N <= 1'b0;
    end else begin
      MEM_GUARD_N <= POWER_GOOD && (pf_q == PF_IDLE || pf_q == PF_GRACE);
    end
  end

endmodule // mfc_top

// file: mfc_top_props.sv
// Port-level assertions for the correction, logging and power-fail block
`timescale 1ns/1ps
module mfc_top_props
  import mfc_pkg::*;
#(
  parameter int unsigned GRACE_CYC = 20
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic MEM_OP_VALID,
  input wire logic [1:0] MEMORY_OP_CODE,
  input wire logic [DATA_W-1:0] WR_DATA,
  input wire logic POWER_LOSS_WARNING_N,
  input wire logic POWER_GOOD,
  input wire logic WR_CHECK_A,
  input wire logic OUT_VALID,
  input wire logic [SYN_W-1:0] OUT_SYNDROME,
  input wire logic ERROR_SEEN,
  input wire logic MEM_GUARD_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Data bits whose code has check bit A set
  localparam logic [15:0] A_MASK = 16'hDC4B;
  int warn_q;
  wire take = MEM_OP_VALID && MEM_GUARD_N;
  wire rd_take = take && MEMORY_OP_CODE[1];
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      warn_q <= 0;
    end else if (POWER_LOSS_WARNING_N) begin
      warn_q <= 0;
    end else if (warn_q < 1000000) begin
      warn_q <= warn_q + 1;
    end
  end
  a_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest held past one cycle");
  a_check_a_write: assert property (take && MEMORY_OP_CODE == OP_WRITE |=>
    WR_CHECK_A == ^($past(WR_DATA) & A_MASK)) else $error("check bit A wrong on write");
  a_check_a_ones: assert property (take && MEMORY_OP_CODE == OP_SET_ONES |=> WR_CHECK_A)
    else $error("check bit A wrong for all ones");
  a_read_answer: assert property (rd_take |-> ##2 OUT_VALID)
    else $error("read result missing");
  a_answer_cause: assert property (OUT_VALID |-> $past(rd_take, 2))
    else $error("result without an accepted read");
  a_error_flag: assert property (ERROR_SEEN == (OUT_VALID && OUT_SYNDROME != 5'h00))
    else $error("error flag disagrees with syndrome");
  a_power_low: assert property (!POWER_GOOD |=> !MEM_GUARD_N)
    else $error("memory open while power is low");
  a_release_cond: assert property ($rose(MEM_GUARD_N) |->
    $past(POWER_LOSS_WARNING_N) && $past(POWER_GOOD)) else $error("guard released too soon");
  a_grace_late: assert property (warn_q > int'(GRACE_CYC) + 2 |-> !MEM_GUARD_N)
    else $error("guard late after warning");
  a_grace_early: assert property (MEM_GUARD_N && POWER_GOOD && warn_q > 0 &&
    warn_q < int'(GRACE_CYC) - 1 |=> MEM_GUARD_N) else $error("guard early after warning");
  c_error_read: cover property (ERROR_SEEN);
  c_set_ones: cover property (take && MEMORY_OP_CODE == OP_SET_ONES);
  c_guard_drop: cover property ($fell(MEM_GUARD_N));
endmodule  // mfc_top_props

bind mfc_top mfc_top_props #(.GRACE_CYC(GRACE_CYC)) props_u (.CORE_CLK, .ARST_N, .AVS_READ,
  .AVS_WRITE, .AVS_WAITREQUEST, .MEM_OP_VALID, .MEMORY_OP_CODE, .WR_DATA, .POWER_LOSS_WARNING_N,
  .POWER_GOOD, .WR_CHECK_A, .OUT_VALID, .OUT_SYNDROME, .ERROR_SEEN, .MEM_GUARD_N);

// file: mfc_array_model.sv
// Main data array model: sixteen data bits plus check bit A per word
`timescale 1ns/1ps
module mfc_array_model (
  input wire logic clk,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [5:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_check_a,
  input wire logic [16:0] flip,
  output logic [15:0] rd_data,
  output logic rd_check_a
);
  logic [16:0] mem_q [64];
  logic [16:0] last_q = 17'h0_0000;
  logic [5:0] pend_q;
  logic pend_v_q = 1'b0;
  wire rd = op_valid && op_code[1];
  // Idle lines toggle, so a stale word is never seen twice
  assign {rd_check_a, rd_data} = rd ? mem_q[addr] ^ flip : ~last_q;
  always_ff @(posedge clk) begin
    last_q <= {rd_check_a, rd_data};
    pend_v_q <= op_valid && op_code[0];
    pend_q <= addr;
    if (op_valid && op_code == 2'h1) begin
      mem_q[addr][15:0] <= wr_data;
    end else if (op_valid && op_code == 2'h3) begin
      mem_q[addr][15:0] <= 16'hFFFF;
    end
    // Bit A arrives a cycle after the data
    if (pend_v_q) begin
      mem_q[pend_q][16] <= wr_check_a;
    end
  end
endmodule  // mfc_array_model

// file: mfc_top_bench.sv
// Self-checking bench for the correction, logging and power-fail block
`timescale 1ns/1ps
module mfc_top_bench;
  import mfc_pkg::*;
  localparam int GR = 20;
  localparam int HD = 40;
  localparam int ST = 10;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] got;
  logic wait_r;
  logic ov = 1'b0;
  logic [1:0] opc = 2'h0;
  logic [14:0] maddr = 15'h0000;
  logic bank = 1'b0;
  logic msb = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdd;
  logic [15:0] od;
  logic rca;
  logic wca;
  logic slot = 1'b0;
  logic alt = 1'b0;
  logic [9:0] alt_a = 10'h000;
  logic warn_n = 1'b1;
  logic pgood = 1'b1;
  logic rail = 1'b0;
  logic ovalid;
  logic [4:0] syn;
  logic err;
  logic guard_n;
  logic [16:0] flip = 17'h0_0000;
  logic dcn = 1'b1;
  int fails = 0;
  int checks = 0;

  mfc_top #(.GRACE_CYC(GR), .HOLD_CYC(HD), .SETTLE_CYC(ST)) dut_u (.CORE_CLK(clk),
    .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r), .MEM_OP_VALID(ov),
    .MEMORY_OP_CODE(opc), .MEM_ADDR(maddr), .BANK_SELECT_BIT(bank), .ADDRESS_MSB_SELECT(msb),
    .WR_DATA(wd), .RD_DATA(rdd), .RD_CHECK_A(rca), .REFRESH_SLOT(slot),
    .DISABLE_CORRECTION_N(dcn), .ALT_LOG_SET(alt), .ALT_LOG_ADDR(alt_a),
    .POWER_LOSS_WARNING_N(warn_n), .POWER_GOOD(pgood), .BACKUP_RAIL_OK(rail),
    .WR_CHECK_A(wca), .OUT_DATA(od), .OUT_VALID(ovalid), .OUT_SYNDROME(syn),
    .ERROR_SEEN(err), .MEM_GUARD_N(guard_n));
  mfc_array_model model_u (.clk(clk), .op_valid(ov), .op_code(opc),
    .addr({msb, bank, maddr[3:0]}), .wr_data(wd), .wr_check_a(wca), .flip(flip),
    .rd_data(rdd), .rd_check_a(rca));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) cmp(0, 1, "bus timeout");
      if (n > 20) wrap_up();
    end while (wait_r !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic memory_op_code(input logic [1:0] c, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    ov <= 1'b1;
    opc <= c;
    maddr <= {11'h000, a};
    wd <= d;
    @(posedge clk);
    ov <= 1'b0;
  endtask
  task automatic rdchk(input logic [1:0] c, input logic [3:0] a, input logic [15:0] ed,
                       input logic [4:0] es);
    memory_op_code(c, a, 16'h0000);
    repeat (2) @(posedge clk);
    cmp(ovalid, 1'b1, "valid");
    cmp(od, ed, "data");
    cmp(syn, es, "syndrome");
    cmp(err, es != 5'h00, "error");
  endtask
  task automatic xfer(input logic [9:0] s, input logic [10:0] l, input logic [2:0] c);
    int n;
    bus(1'b1, REG_START, {22'h00_0000, s});
    bus(1'b1, REG_LEN, {21'h00_0000, l});
    bus(1'b1, REG_CMD, {29'h0000_0000, c});
    bus(1'b0, REG_STAT, 32'h0000_0000);
    cmp(got[STAT_BUSY_BIT], 1'b1, "idle without slot");
    n = 0;
    do begin
      @(posedge clk);
      slot <= 1'b1;
      @(posedge clk);
      slot <= 1'b0;
      bus(1'b0, REG_STAT, 32'h0000_0000);
      n++;
      if (n > 1100) cmp(0, 1, "transfer timeout");
      if (n > 1100) wrap_up();
    end while (got[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic s_clear();
    xfer(10'h000, 11'h020, 3'h1);
    cmp(got[STAT_CPERR_BIT], 1'b0, "copy flag");
    bus(1'b0, 8'h80, 32'h0000_0000);
    cmp(got, 32'h0000_0000, "cleared log");
    bus(1'b0, 8'h20, 32'h0000_0000);
    cmp(got, 32'h0000_0000, "unmapped");
  endtask
  task automatic s_code();
    memory_op_code(2'h1, 4'h2, 16'hA5C3);
    @(posedge clk);
    cmp(wca, ^(16'hA5C3 & 16'hDC4B), "bit A");
    rdchk(2'h2, 4'h2, 16'hA5C3, 5'h00);
    for (int i = 0; i < 16; i++) begin
      flip <= 17'h0_0001 << i;
      rdchk(2'h2, 4'h2, 16'hA5C3, DATA_CODE[i]);
    end
    flip <= 17'h1_0000;
    rdchk(2'h2, 4'h2, 16'hA5C3, 5'h01);
    // Correction off: raw word passes, error still reported
    flip <= 17'h0_0004;
    dcn <= 1'b0;
    rdchk(2'h2, 4'h2, 16'hA5C7, 5'h06);
    dcn <= 1'b1;
    flip <= 17'h0_0000;
    memory_op_code(2'h1, 4'h5, 16'h1234);
    rdchk(2'h3, 4'h5, 16'h1234, 5'h00);
    rdchk(2'h2, 4'h5, 16'hFFFF, 5'h00);
  endtask
  task automatic s_sel();
    memory_op_code(2'h1, 4'h7, 16'h0F0F);
    {msb, bank} <= 2'h3;
    memory_op_code(2'h1, 4'h7, 16'hF00F);
    {msb, bank} <= 2'h0;
    rdchk(2'h2, 4'h7, 16'h0F0F, 5'h00);
    {msb, bank} <= 2'h3;
    rdchk(2'h2, 4'h7, 16'hF00F, 5'h00);
  endtask
  task automatic s_log();
    memory_op_code(2'h1, 4'h2, 16'h3C5A);
    flip <= 17'h0_0001;
    rdchk(2'h2, 4'h2, 16'h3C5A, 5'h03);
    flip <= 17'h0_0000;
    {msb, bank} <= 2'h0;
    bus(1'b0, REG_SYN, 32'h0000_0000);
    cmp(got, 32'h0000_0003, "syndrome reg");
    xfer(10'h067, 11'h001, 3'h1);
    cmp(got[STAT_CPERR_BIT], 1'b1, "copy flag");
    bus(1'b0, 8'h8C, 32'h0000_0000);
    cmp(got[7], 1'b1, "logged entry");
    bus(1'b1, 8'h8C, 32'h0000_0000);
    xfer(10'h067, 11'h001, 3'h3);
    bus(1'b1, REG_STAT, 32'h0000_0001);
    xfer(10'h067, 11'h001, 3'h1);
    cmp(got[STAT_CPERR_BIT], 1'b0, "entry cleared");
    @(posedge clk);
    alt <= 1'b1;
    alt_a <= 10'h068;
    @(posedge clk);
    alt <= 1'b0;
    xfer(10'h067, 11'h002, 3'h5);
    bus(1'b0, 8'h8C, 32'h0000_0000);
    cmp(got, 32'h0000_0100, "second log");
  endtask
  task automatic s_power();
    int n;
    n = 0;
    @(posedge clk);
    warn_n <= 1'b0;
    while (guard_n === 1'b1 && n < GR + 10) begin
      @(posedge clk);
      n++;
    end
    cmp(n >= GR && n <= GR + 3, 1'b1, "grace");
    memory_op_code(2'h2, 4'h2, 16'h0000);
    repeat (2) @(posedge clk);
    cmp(ovalid, 1'b0, "guarded read");
    warn_n <= 1'b1;
    n = 0;
    while (guard_n !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    cmp(n >= HD - 6 && n >= ST && n < 400, 1'b1, "hold");
    pgood <= 1'b0;
    repeat (2) @(posedge clk);
    cmp(guard_n, 1'b0, "power low");
    bus(1'b0, REG_STAT, 32'h0000_0000);
    cmp(got[STAT_GUARD_BIT], 1'b1, "guard bit");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rail <= 1'b1;
    repeat (4) @(posedge clk);
    s_clear();
    s_code();
    s_sel();
    s_log();
    s_power();
    wrap_up();
  end
endmodule  // mfc_top_bench
